// ===== design/panel_pkg.sv
// Summary of operation
// - timecode sent to the ISDN line is reader one, slave position or generator
// - during editing, holding increment and decrement together zeroes the value
// - generator frame rate is 24, 25, 29 or 30 fps, 25 nominal
// - power-up reset keeps battery-backed positions, offsets and configuration
// - corrupted backed memory is reinitialised whole and a hard reset flagged
// - select plus set together restarts the power-up sequence, clearing master and two-way selection
// - select plus freeze erases backed memory; faulty panel needs power-up hold
// - two-way key picks one-way or two-way ISDN offset as active
// - ISDN trim_down lowers the active ISDN offset by one frame
// - ISDN trim_up raises the active ISDN offset by one frame
// - master timecode is jam source timecode plus local offset
// - capture_alignment loads local offset keeping master/slave relation
// - local trim_down and trim_up move local offset one frame each way
// - local trim_down and trim_up together zero the local offset
// - machine follows the generator, which free-runs with no master chosen
// - reader master applies config 2: jam on, reader one, video reference
// - ISDN master applies config 3: jam on, serial timecode, video reference
// - no master applies config 1: jam off, video reference
// - commands go to local port for local_target, ISDN link for remote_target
// - motion indicators are off while the machine is not remote enabled
// - any command except record or chase clears follow mode; record leaves it, chase sets it
// - record sends insert-record with channels from the machine setup
// - active ISDN offset is added to timecode before the ISDN encoder
// - ISDN offset is applied only in play
package panel_pkg;

  localparam int TC_W = 24;
  localparam int CH_W = 8;
  localparam int DIGITS = 8;
  localparam logic [15:0] MEM_MARK = 16'h5a3c;  // arbitrary validity mark
  localparam logic [2:0] SETTLE_CYC = 3'h3;     // synchroniser fill time
  localparam logic [TC_W-1:0] TC_ZERO = 24'h0;
  localparam logic [TC_W-1:0] TC_ONE = 24'h1;

  typedef struct packed {
    logic inc;
    logic dec;
    logic left;
    logic right;
    logic select;
    logic set;
    logic freeze;
    logic two_way;
    logic itrim_dn;
    logic itrim_up;
    logic capture_alignment;
    logic ltrim_dn;
    logic ltrim_up;
    logic rdr_master;
    logic isdn_master;
    logic play;
    logic stop;
    logic rew;
    logic ffwd;
    logic record;
    logic chase;
    logic local_key;
    logic remote_key;
  } keys_t;

  typedef enum logic [1:0] {
    SEND_READER_ONE     = 2'h0,
    SEND_SLAVE_POSITION = 2'h1,
    SEND_GENERATOR      = 2'h2
  } send_src_t;

  typedef enum logic [1:0] {
    RATE_24 = 2'h0,
    RATE_25 = 2'h1,
    RATE_29 = 2'h2,
    RATE_30 = 2'h3
  } rate_t;
  localparam rate_t RATE_NOMINAL = RATE_25;

  typedef enum logic [1:0] {
    JAM_READER_ONE    = 2'h0,
    JAM_SERIAL_SOURCE = 2'h1,
    JAM_NONE          = 2'h2
  } jam_src_t;

  localparam logic [1:0] CFG_FREE = 2'h1;
  localparam logic [1:0] CFG_READER = 2'h2;
  localparam logic [1:0] CFG_ISDN = 2'h3;

  typedef struct packed {
    logic [1:0] cfg_num;
    logic       jam_on;
    jam_src_t   jam_src;
    logic       ref_video;
  } gen_cfg_t;

  typedef enum logic [2:0] {
    CMD_NONE    = 3'h0,
    CMD_PLAY    = 3'h1,
    CMD_STOP    = 3'h2,
    CMD_REW     = 3'h3,
    CMD_FFWD    = 3'h4,
    CMD_INS_REC = 3'h5,
    CMD_CHASE   = 3'h6
  } cmd_t;

  typedef struct packed {
    logic            valid;
    cmd_t            code;
    logic [CH_W-1:0] channels;
  } mach_cmd_t;

  typedef struct packed {
    logic play;
    logic stop;
    logic rew;
    logic ffwd;
    logic rec;
    logic chase;
  } leds_t;

  typedef enum logic [1:0] {
    ST_START = 2'h0,
    ST_CHECK = 2'h1,
    ST_RUN   = 2'h3,
    ST_INIT  = 2'h2
  } pu_state_t;

endpackage

// ===== design/key_sync.sv
`timescale 1ns/100ps
module key_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // raw pins and synchronised results
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] prev_ff;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        meta_ff[i] <= 1'b0;
        sync_ff[i] <= 1'b0;
        prev_ff[i] <= 1'b0;
      end else begin
        meta_ff[i] <= raw[i];
        sync_ff[i] <= meta_ff[i];
        prev_ff[i] <= sync_ff[i];
      end
    end
    assign level[i] = sync_ff[i];
    assign rise[i] = sync_ff[i] & ~prev_ff[i];
  end

endmodule

// ===== design/digit_editor.sv
`timescale 1ns/100ps
module digit_editor (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // key events
  input  wire logic        edit_en,
  input  wire logic        inc,
  input  wire logic        dec,
  input  wire logic        inc_held,
  input  wire logic        dec_held,
  input  wire logic        left,
  input  wire logic        right,
  // edited value, one bcd digit per nibble
  output logic      [31:0] value_ff
);

  logic [31:0] nxt_value;
  logic [2:0]  cur_ff;
  logic [2:0]  nxt_cur;

  always_comb begin
    nxt_cur = cur_ff;
    if (edit_en && left)
      nxt_cur = cur_ff + 3'h1;
    else if (edit_en && right)
      nxt_cur = cur_ff - 3'h1;
  end

  // chord beats a single step so a clear never leaves one digit moved
  for (genvar d = 0; d < panel_pkg::DIGITS; d++) begin : g_dig
    logic [3:0] dg;
    assign dg = value_ff[4*d +: 4];
    always_comb begin
      nxt_value[4*d +: 4] = dg;
      if (edit_en && inc_held && dec_held)
        nxt_value[4*d +: 4] = 4'h0;
      else if (edit_en && cur_ff == 3'(d) && inc)
        nxt_value[4*d +: 4] = (dg == 4'h9) ? 4'h0 : dg + 4'h1;
      else if (edit_en && cur_ff == 3'(d) && dec)
        nxt_value[4*d +: 4] = (dg == 4'h0) ? 4'h9 : dg - 4'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      value_ff <= 32'h0;
      cur_ff <= 3'h0;
    end else begin
      value_ff <= nxt_value;
      cur_ff <= nxt_cur;
    end
  end

  chk_clear_all: assert property (@(posedge clk) disable iff (rst)
    edit_en && inc_held && dec_held |=> value_ff == 32'h0)
    else $error("edit value not cleared by inc+dec chord");

endmodule

// ===== design/panel_ctrl.sv
`timescale 1ns/100ps
module panel_ctrl (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // front panel keys, raw pins
  input  wire panel_pkg::keys_t           keys_raw,
  input  wire logic                       edit_mode,
  input  wire logic                       panel_fault,
  // battery-backed memory check and settings
  input  wire logic                       mem_check_ok,
  input  wire logic                       cfg_wr,
  input  wire panel_pkg::send_src_t       cfg_send_src,
  input  wire panel_pkg::rate_t           cfg_rate,
  input  wire logic [panel_pkg::CH_W-1:0] rec_channels,
  // timecode sources
  input  wire logic [panel_pkg::TC_W-1:0] reader_tc,
  input  wire logic [panel_pkg::TC_W-1:0] slave_tc,
  input  wire logic [panel_pkg::TC_W-1:0] gen_tc,
  input  wire logic [panel_pkg::TC_W-1:0] isdn_rx_tc,
  input  wire logic                       in_play,
  input  wire logic                       remote_enabled,
  // timecode results
  output logic      [panel_pkg::TC_W-1:0] isdn_tx_tc_ff,
  output logic      [panel_pkg::TC_W-1:0] master_tc_ff,
  output logic      [panel_pkg::TC_W-1:0] act_ofs_ff,
  output logic      [panel_pkg::TC_W-1:0] loc_ofs_out_ff,
  output logic                            two_way_ff,
  // generator control
  output panel_pkg::gen_cfg_t             gen_cfg_ff,
  output panel_pkg::rate_t                gen_rate_ff,
  // machine control
  output panel_pkg::mach_cmd_t            local_cmd_ff,
  output panel_pkg::mach_cmd_t            isdn_cmd_ff,
  output logic                            remote_target_ff,
  output logic                            follow_ff,
  output panel_pkg::leds_t                leds_ff,
  // status
  output logic                            hard_rst_ff,
  output logic      [31:0]                edit_value_ff
);

  localparam int KW = $bits(panel_pkg::keys_t);

  panel_pkg::keys_t kl;
  panel_pkg::keys_t kr;
  logic [KW-1:0]    kl_v;
  logic [KW-1:0]    kr_v;

  key_sync #(.W(KW)) u_keys (
    .clk   (clk),
    .rst   (rst),
    .raw   (keys_raw),
    .level (kl_v),
    .rise  (kr_v)
  );
  assign kl = panel_pkg::keys_t'(kl_v);
  assign kr = panel_pkg::keys_t'(kr_v);

  // ************************************************************
  // reset sequencing
  // ************************************************************
  panel_pkg::pu_state_t st_ff;
  panel_pkg::pu_state_t nxt_st;
  logic [2:0]           cnt_ff;
  logic [2:0]           nxt_cnt;
  logic                 nxt_hard;
  logic                 run;
  logic                 soft_req;
  logic                 hard_req;
  logic                 mem_init;
  logic [15:0]          sig_ff;
  logic [15:0]          nxt_sig;

  assign run = (st_ff == panel_pkg::ST_RUN);
  assign soft_req = run && kl.select && kl.set &&
                    (kr.select || kr.set);
  // a panel in fault cannot be trusted to decode the select plus freeze chord while running
  assign hard_req = run && !panel_fault && kl.select && kl.freeze &&
                    (kr.select || kr.freeze);
  assign mem_init = (st_ff == panel_pkg::ST_INIT);

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_hard = hard_rst_ff;
    case (st_ff)
      panel_pkg::ST_START: begin
        nxt_cnt = cnt_ff + 3'h1;
        if (cnt_ff == panel_pkg::SETTLE_CYC)
          nxt_st = panel_pkg::ST_CHECK;
      end
      panel_pkg::ST_CHECK: begin
        nxt_cnt = 3'h0;
        if (kl.select && kl.freeze)
          nxt_st = panel_pkg::ST_INIT;
        // a mark never written is unknown: only a proven good mark may run
        else if (mem_check_ok && sig_ff == panel_pkg::MEM_MARK)
          nxt_st = panel_pkg::ST_RUN;
        else begin
          nxt_st = panel_pkg::ST_INIT;
          nxt_hard = 1'b1;
        end
      end
      panel_pkg::ST_RUN: begin
        if (soft_req) begin
          nxt_st = panel_pkg::ST_START;
          nxt_hard = 1'b0;
        end else if (hard_req)
          nxt_st = panel_pkg::ST_INIT;
      end
      panel_pkg::ST_INIT: begin
        nxt_st = panel_pkg::ST_RUN;
        nxt_hard = 1'b1;
      end
      default: nxt_st = panel_pkg::ST_START;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= panel_pkg::ST_START;
      cnt_ff <= 3'h0;
      hard_rst_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      hard_rst_ff <= nxt_hard;
    end
  end

  // ************************************************************
  // battery-backed store
  // ************************************************************
  // no reset on purpose: contents must survive power-up and soft reset
  logic [panel_pkg::TC_W-1:0] ow_ofs_ff;
  logic [panel_pkg::TC_W-1:0] tw_ofs_ff;
  logic [panel_pkg::TC_W-1:0] loc_ofs_ff;
  logic [panel_pkg::TC_W-1:0] nxt_ow;
  logic [panel_pkg::TC_W-1:0] nxt_tw;
  logic [panel_pkg::TC_W-1:0] nxt_loc;
  logic [panel_pkg::TC_W-1:0] nxt_act;
  logic [panel_pkg::TC_W-1:0] jam_tc;
  panel_pkg::send_src_t   send_ff;
  panel_pkg::send_src_t   nxt_send;
  panel_pkg::rate_t       rate_ff;
  panel_pkg::rate_t       nxt_rate;
  logic                   iup;
  logic                   idn;
  logic                   lup;
  logic                   ldn;
  logic                   lclr;

  assign iup = run && kr.itrim_up && !kl.itrim_dn;
  assign idn = run && kr.itrim_dn && !kl.itrim_up;
  assign lclr = run && kl.ltrim_up && kl.ltrim_dn &&
                (kr.ltrim_up || kr.ltrim_dn);
  assign lup = run && kr.ltrim_up && !kl.ltrim_dn;
  assign ldn = run && kr.ltrim_dn && !kl.ltrim_up;

  always_comb begin
    nxt_sig = sig_ff;
    nxt_ow = ow_ofs_ff;
    nxt_tw = tw_ofs_ff;
    nxt_loc = loc_ofs_ff;
    nxt_send = send_ff;
    nxt_rate = rate_ff;
    if (mem_init) begin
      nxt_sig = panel_pkg::MEM_MARK;
      nxt_ow = panel_pkg::TC_ZERO;
      nxt_tw = panel_pkg::TC_ZERO;
      nxt_loc = panel_pkg::TC_ZERO;
      nxt_send = panel_pkg::SEND_READER_ONE;
      nxt_rate = panel_pkg::RATE_NOMINAL;
    end else begin
      if (run && cfg_wr) begin
        nxt_send = cfg_send_src;
        nxt_rate = cfg_rate;
      end
      if (iup && two_way_ff)
        nxt_tw = tw_ofs_ff + panel_pkg::TC_ONE;
      else if (iup)
        nxt_ow = ow_ofs_ff + panel_pkg::TC_ONE;
      else if (idn && two_way_ff)
        nxt_tw = tw_ofs_ff - panel_pkg::TC_ONE;
      else if (idn)
        nxt_ow = ow_ofs_ff - panel_pkg::TC_ONE;
      if (lclr)
        nxt_loc = panel_pkg::TC_ZERO;
      else if (run && kr.capture_alignment)
        nxt_loc = slave_tc - jam_tc;
      else if (lup)
        nxt_loc = loc_ofs_ff + panel_pkg::TC_ONE;
      else if (ldn)
        nxt_loc = loc_ofs_ff - panel_pkg::TC_ONE;
    end
    nxt_act = two_way_ff ? nxt_tw : nxt_ow;
  end

  always_ff @(posedge clk) begin
    sig_ff <= nxt_sig;
    ow_ofs_ff <= nxt_ow;
    tw_ofs_ff <= nxt_tw;
    loc_ofs_ff <= nxt_loc;
    send_ff <= nxt_send;
    rate_ff <= nxt_rate;
  end

  // ************************************************************
  // master selection and timecode paths
  // ************************************************************
  logic                   rdr_sel_ff;
  logic                   isdn_sel_ff;
  logic                   nxt_rdr_sel;
  logic                   nxt_isdn_sel;
  logic                   nxt_two_way;
  logic [panel_pkg::TC_W-1:0] src_tc;
  logic [panel_pkg::TC_W-1:0] nxt_tx;
  panel_pkg::gen_cfg_t    nxt_cfg;

  always_comb begin
    nxt_rdr_sel = rdr_sel_ff;
    nxt_isdn_sel = isdn_sel_ff;
    nxt_two_way = two_way_ff;
    if (run && kr.two_way)
      nxt_two_way = !two_way_ff;
    if (run && kr.rdr_master) begin
      nxt_rdr_sel = !rdr_sel_ff;
      nxt_isdn_sel = 1'b0;
    end else if (run && kr.isdn_master) begin
      nxt_isdn_sel = !isdn_sel_ff;
      nxt_rdr_sel = 1'b0;
    end
    nxt_cfg.ref_video = 1'b1;
    if (rdr_sel_ff) begin
      nxt_cfg.cfg_num = panel_pkg::CFG_READER;
      nxt_cfg.jam_on = 1'b1;
      nxt_cfg.jam_src = panel_pkg::JAM_READER_ONE;
      jam_tc = reader_tc;
    end else if (isdn_sel_ff) begin
      nxt_cfg.cfg_num = panel_pkg::CFG_ISDN;
      nxt_cfg.jam_on = 1'b1;
      nxt_cfg.jam_src = panel_pkg::JAM_SERIAL_SOURCE;
      jam_tc = isdn_rx_tc;
    end else begin
      nxt_cfg.cfg_num = panel_pkg::CFG_FREE;
      nxt_cfg.jam_on = 1'b0;
      nxt_cfg.jam_src = panel_pkg::JAM_NONE;
      jam_tc = gen_tc;
    end
    case (send_ff)
      panel_pkg::SEND_READER_ONE:     src_tc = reader_tc;
      panel_pkg::SEND_SLAVE_POSITION: src_tc = slave_tc;
      panel_pkg::SEND_GENERATOR:      src_tc = gen_tc;
      default:                        src_tc = gen_tc;
    endcase
    // stationary code goes out untouched so a parked machine stays put
    nxt_tx = in_play ? src_tc + act_ofs_ff : src_tc;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdr_sel_ff <= 1'b0;
      isdn_sel_ff <= 1'b0;
      two_way_ff <= 1'b0;
      gen_cfg_ff <= '0;
      gen_rate_ff <= panel_pkg::RATE_NOMINAL;
      act_ofs_ff <= panel_pkg::TC_ZERO;
      loc_ofs_out_ff <= panel_pkg::TC_ZERO;
      isdn_tx_tc_ff <= panel_pkg::TC_ZERO;
      master_tc_ff <= panel_pkg::TC_ZERO;
    end else if (soft_req) begin
      rdr_sel_ff <= 1'b0;
      isdn_sel_ff <= 1'b0;
      two_way_ff <= 1'b0;
    end else begin
      rdr_sel_ff <= nxt_rdr_sel;
      isdn_sel_ff <= nxt_isdn_sel;
      two_way_ff <= nxt_two_way;
      gen_cfg_ff <= nxt_cfg;
      gen_rate_ff <= rate_ff;
      act_ofs_ff <= nxt_act;
      loc_ofs_out_ff <= nxt_loc;
      isdn_tx_tc_ff <= nxt_tx;
      master_tc_ff <= jam_tc + loc_ofs_ff;
    end
  end

  // ************************************************************
  // machine control
  // ************************************************************
  panel_pkg::mach_cmd_t cmd;
  panel_pkg::leds_t     nxt_leds;
  panel_pkg::leds_t     last_ff;
  logic                 nxt_far;
  logic                 nxt_follow;

  always_comb begin
    cmd = '0;
    nxt_far = remote_target_ff;
    nxt_follow = follow_ff;
    nxt_leds = last_ff;
    if (run && kr.local_key)
      nxt_far = 1'b0;
    else if (run && kr.remote_key)
      nxt_far = 1'b1;
    if (run) begin
      cmd.valid = 1'b1;
      if (kr.play)
        cmd.code = panel_pkg::CMD_PLAY;
      else if (kr.stop)
        cmd.code = panel_pkg::CMD_STOP;
      else if (kr.rew)
        cmd.code = panel_pkg::CMD_REW;
      else if (kr.ffwd)
        cmd.code = panel_pkg::CMD_FFWD;
      else if (kr.record) begin
        cmd.code = panel_pkg::CMD_INS_REC;
        cmd.channels = rec_channels;
      end else if (kr.chase)
        cmd.code = panel_pkg::CMD_CHASE;
      else
        cmd.valid = 1'b0;
    end
    if (cmd.valid && cmd.code == panel_pkg::CMD_CHASE)
      nxt_follow = 1'b1;
    else if (cmd.valid && cmd.code != panel_pkg::CMD_INS_REC)
      nxt_follow = 1'b0;
    if (cmd.valid) begin
      nxt_leds = '0;
      nxt_leds.play = (cmd.code == panel_pkg::CMD_PLAY);
      nxt_leds.stop = (cmd.code == panel_pkg::CMD_STOP);
      nxt_leds.rew = (cmd.code == panel_pkg::CMD_REW);
      nxt_leds.ffwd = (cmd.code == panel_pkg::CMD_FFWD);
      nxt_leds.rec = (cmd.code == panel_pkg::CMD_INS_REC);
    end
    nxt_leds.chase = nxt_follow;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      remote_target_ff <= 1'b0;
      follow_ff <= 1'b0;
      last_ff <= '0;
      leds_ff <= '0;
      local_cmd_ff <= '0;
      isdn_cmd_ff <= '0;
    end else begin
      remote_target_ff <= nxt_far;
      follow_ff <= nxt_follow;
      last_ff <= nxt_leds;
      leds_ff <= remote_enabled ? nxt_leds : '0;
      local_cmd_ff <= nxt_far ? '0 : cmd;
      isdn_cmd_ff <= nxt_far ? cmd : '0;
    end
  end

  digit_editor u_edit (
    .clk      (clk),
    .rst      (rst),
    .edit_en  (edit_mode && run),
    .inc      (kr.inc && !kl.dec),
    .dec      (kr.dec && !kl.inc),
    .inc_held (kl.inc),
    .dec_held (kl.dec),
    .left     (kr.left),
    .right    (kr.right),
    .value_ff (edit_value_ff)
  );

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_chase;
    run && kr.chase && !kr.play && !kr.stop && !kr.rew && !kr.ffwd &&
    !kr.record;
  endsequence
  sequence s_other_cmd;
    cmd.valid && cmd.code != panel_pkg::CMD_CHASE &&
    cmd.code != panel_pkg::CMD_INS_REC;
  endsequence

  chk_send_gen: assert property (
    send_ff == panel_pkg::SEND_GENERATOR && !in_play && !soft_req
    |=> isdn_tx_tc_ff == $past(gen_tc))
    else $error("isdn timecode not taken from generator");
  chk_play_ofs: assert property (
    in_play && !soft_req
    |=> isdn_tx_tc_ff == $past(src_tc) + $past(act_ofs_ff))
    else $error("isdn offset missing in play");
  chk_trim_up: assert property (
    iup && !kr.two_way && !mem_init && !soft_req
    ##1 !iup && !idn && !kr.two_way && !soft_req
    |=> act_ofs_ff == $past(act_ofs_ff, 2) + panel_pkg::TC_ONE)
    else $error("isdn trim up not one frame");
  chk_trim_dn: assert property (
    idn && !kr.two_way && !mem_init && !soft_req
    ##1 !iup && !idn && !kr.two_way && !soft_req
    |=> act_ofs_ff == $past(act_ofs_ff, 2) - panel_pkg::TC_ONE)
    else $error("isdn trim down not one frame");
  chk_loc_clear: assert property (
    lclr && !soft_req |=> loc_ofs_out_ff == panel_pkg::TC_ZERO)
    else $error("local offset not cleared by chord");
  chk_cfg_rdr: assert property (
    rdr_sel_ff && !soft_req
    |=> gen_cfg_ff.cfg_num == panel_pkg::CFG_READER && gen_cfg_ff.jam_on)
    else $error("reader master config wrong");
  chk_leds_off: assert property (
    !remote_enabled |=> leds_ff == '0)
    else $error("motion indicators lit without remote enable");
  chk_follow_clr: assert property (
    s_other_cmd |=> !follow_ff)
    else $error("follow survives a stop command");
  chk_follow_set: assert property (
    s_chase |=> follow_ff)
    else $error("chase did not start follow");
  chk_rec_keep: assert property (
    cmd.valid && cmd.code == panel_pkg::CMD_INS_REC |=> $stable(follow_ff))
    else $error("record changed follow state");
  chk_hard_flag: assert property (
    st_ff == panel_pkg::ST_CHECK && !mem_check_ok
    |=> mem_init ##1 run && hard_rst_ff && sig_ff == panel_pkg::MEM_MARK)
    else $error("bad memory not reinitialised");
  chk_route: assert property (
    cmd.valid && remote_target_ff && !(run && kr.local_key)
    |=> isdn_cmd_ff.valid && !local_cmd_ff.valid)
    else $error("remote command not sent over isdn");

endmodule

// ===== tb/tape_model.sv
`timescale 1ns/100ps
module tape_model (
  // clock
  input  wire logic                 clk,
  // commands from the panel
  input  wire panel_pkg::mach_cmd_t local_cmd,
  input  wire panel_pkg::mach_cmd_t isdn_cmd,
  // positions and what was received
  output logic [23:0]               slave_tc,
  output logic [23:0]               isdn_rx_tc,
  output panel_pkg::mach_cmd_t      local_target_seen,
  output panel_pkg::mach_cmd_t      far_seen
);
  // fixed positions keep expected sums simple
  assign slave_tc = 24'h001234;
  assign isdn_rx_tc = 24'h000500;
  // commands are one-cycle pulses, so latch them
  always @(posedge clk) begin
    if (local_cmd.valid) local_target_seen <= local_cmd;
    if (isdn_cmd.valid) far_seen <= isdn_cmd;
  end
endmodule

// ===== tb/isdn_timecode_panel_control_bench.sv
`timescale 1ns/100ps
module isdn_timecode_panel_control_bench;
  // ****
  // stimulus
  // ****
  typedef struct packed {
    logic [22:0] k;
    logic [23:0] a;
    logic [23:0] l;
    logic [5:0]  c;
  } row_t;
  logic clk, rst, edit_mode, panel_fault, mem_check_ok, cfg_wr, in_play;
  logic remote_enabled, two_way_ff, remote_target_ff, follow_ff, hard_rst_ff;
  logic [7:0] rec_channels;
  logic [23:0] reader_tc, slave_tc, gen_tc, isdn_rx_tc, isdn_tx_tc_ff;
  logic [23:0] master_tc_ff, act_ofs_ff, loc_ofs_out_ff;
  logic [31:0] edit_value_ff;
  panel_pkg::keys_t keys_raw;
  panel_pkg::send_src_t cfg_send_src;
  panel_pkg::rate_t cfg_rate, gen_rate_ff;
  panel_pkg::gen_cfg_t gen_cfg_ff;
  panel_pkg::leds_t leds_ff;
  panel_pkg::mach_cmd_t local_cmd_ff, isdn_cmd_ff, local_target_seen, far_seen;
  int err_count, checks;
  logic [23:0] srcs [3] = '{24'h000100, 24'h001234, 24'h000777};
  row_t rows [12] = '{
    '{23'h2000, 24'h1, 24'h0, 6'h11}, '{23'h2000, 24'h2, 24'h0, 6'h11},
    '{23'h4000, 24'h1, 24'h0, 6'h11}, '{23'h8000, 24'h0, 24'h0, 6'h11},
    '{23'h4000, 24'hffffff, 24'h0, 6'h11}, '{23'h8000, 24'h1, 24'h0, 6'h11},
    '{23'h0400, 24'h1, 24'h1, 6'h11}, '{23'h0c00, 24'h1, 24'h0, 6'h11},
    '{23'h0800, 24'h1, 24'hffffff, 6'h11},
    '{23'h0100, 24'h1, 24'hffffff, 6'h3b},
    '{23'h0100, 24'h1, 24'hffffff, 6'h11},
    '{23'h0200, 24'h1, 24'hffffff, 6'h29}};

  panel_ctrl panel_ctrl_inst (.clk, .rst, .keys_raw, .edit_mode,
    .panel_fault, .mem_check_ok, .cfg_wr, .cfg_send_src, .cfg_rate,
    .rec_channels, .reader_tc, .slave_tc, .gen_tc, .isdn_rx_tc, .in_play,
    .remote_enabled, .isdn_tx_tc_ff, .master_tc_ff, .act_ofs_ff,
    .loc_ofs_out_ff, .two_way_ff, .gen_cfg_ff, .gen_rate_ff, .local_cmd_ff,
    .isdn_cmd_ff, .remote_target_ff, .follow_ff, .leds_ff, .hard_rst_ff,
    .edit_value_ff);
  tape_model tape_model_inst (.clk, .local_cmd(local_cmd_ff),
    .isdn_cmd(isdn_cmd_ff), .slave_tc, .isdn_rx_tc, .local_target_seen, .far_seen);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  // keys pass a two-stage synchroniser, so hold well past it
  task automatic press(logic [22:0] k, int hold = 6);
    keys_raw <= k;
    repeat (hold) @(posedge clk);
    keys_raw <= '0;
    repeat (12) @(posedge clk);
  endtask

  task automatic close_out;
    $display("mismatches %0d in %0d checks", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    {rst, mem_check_ok} = 2'b11;
    {edit_mode, panel_fault, cfg_wr, in_play, remote_enabled} = '0;
    keys_raw = '0;
    cfg_send_src = panel_pkg::SEND_READER_ONE;
    cfg_rate = panel_pkg::RATE_NOMINAL;
    rec_channels = 8'h5a;
    reader_tc = srcs[0];
    gen_tc = srcs[2];
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    chk("hard_rst", 1, hard_rst_ff);
    foreach (rows[i]) begin
      press(rows[i].k);
      chk("act_ofs", rows[i].a, act_ofs_ff);
      chk("loc_ofs", rows[i].l, loc_ofs_out_ff);
      chk("cfg", rows[i].c, gen_cfg_ff & (rows[i].c[3] ? 6'h3f : 6'h39));
    end
    chk("master", 24'h0000ff, master_tc_ff);
    chk("two_way", 0, two_way_ff);
    for (int s = 0; s < 3; s++) begin
      cfg_send_src <= panel_pkg::send_src_t'(s);
      cfg_rate <= panel_pkg::RATE_24;
      cfg_wr <= 1'b1;
      in_play <= 1'b0;
      @(posedge clk);
      cfg_wr <= 1'b0;
      repeat (4) @(posedge clk);
      chk("tx_still", srcs[s], isdn_tx_tc_ff);
      in_play <= 1'b1;
      repeat (3) @(posedge clk);
      chk("tx_play", srcs[s] + 24'h1, isdn_tx_tc_ff);
    end
    chk("rate", panel_pkg::RATE_24, gen_rate_ff);
    press(23'h1000);
    chk("master", 24'h001234, master_tc_ff);
    remote_enabled <= 1'b1;
    press(23'h4);
    chk("local_target_code", panel_pkg::CMD_CHASE, local_target_seen.code);
    chk("follow", 1, follow_ff);
    press(23'h8);
    chk("local_target_rec", {1'b1, panel_pkg::CMD_INS_REC, 8'h5a}, local_target_seen);
    chk("follow", 1, follow_ff);
    press(23'h1);
    chk("far_sel", 1, remote_target_ff);
    press(23'h80);
    chk("far_code", panel_pkg::CMD_PLAY, far_seen.code);
    chk("follow", 0, follow_ff);
    chk("leds_on", 6'h20, leds_ff);
    press(23'h20);
    chk("far_rew", panel_pkg::CMD_REW, far_seen.code);
    press(23'h10);
    chk("far_ffwd", panel_pkg::CMD_FFWD, far_seen.code);
    remote_enabled <= 1'b0;
    repeat (3) @(posedge clk);
    chk("leds", 0, leds_ff);
    edit_mode <= 1'b1;
    press(23'h400000);
    chk("edit_inc", 32'h1, edit_value_ff);
    press(23'h600000);
    chk("edit_clr", 0, edit_value_ff);
    edit_mode <= 1'b0;
    press(23'h060000);
    chk("hard_rst", 0, hard_rst_ff);
    chk("act_kept", 1, act_ofs_ff);
    chk("rate_kept", panel_pkg::RATE_24, gen_rate_ff);
    press(23'h050000);
    chk("hard_rst", 1, hard_rst_ff);
    chk("act_wiped", 0, act_ofs_ff);
    panel_fault <= 1'b1;
    press(23'h2000);
    press(23'h050000);
    chk("act_fault", 1, act_ofs_ff);
    keys_raw <= 23'h050000;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    press(23'h050000, 12);
    chk("hard_rst", 1, hard_rst_ff);
    chk("act_boot", 0, act_ofs_ff);
    press(23'h2000);
    mem_check_ok <= 1'b0;
    press(23'h060000);
    chk("hard_rst", 1, hard_rst_ff);
    chk("act_bad_mem", 0, act_ofs_ff);
    close_out();
  end
endmodule
